// >>> verilog/cmtx_pkg.sv
// Constants, register map and state type of the infrared carrier modulator.
package cmtx_pkg;

    // Register byte offsets on the APB bus, one aligned word each.
    localparam logic [7:0] CMTX_OFS_PRI_HIGH  = 8'h00;
    localparam logic [7:0] CMTX_OFS_PRI_LOW   = 8'h04;
    localparam logic [7:0] CMTX_OFS_SEC_HIGH  = 8'h08;
    localparam logic [7:0] CMTX_OFS_SEC_LOW   = 8'h0C;
    localparam logic [7:0] CMTX_OFS_OUT_CTRL  = 8'h10;
    localparam logic [7:0] CMTX_OFS_MOD_STAT  = 8'h14;
    localparam logic [7:0] CMTX_OFS_MARK_HIGH = 8'h18;
    localparam logic [7:0] CMTX_OFS_MARK_LOW  = 8'h1C;
    localparam logic [7:0] CMTX_OFS_SPACE_HIGH = 8'h20;
    localparam logic [7:0] CMTX_OFS_SPACE_LOW = 8'h24;

    // Output control register fields.
    localparam int CMTX_OC_LATCH = 7;
    localparam int CMTX_OC_POL   = 6;
    localparam int CMTX_OC_PEN   = 5;

    // Modulator status and control register fields.
    localparam int CMTX_MSC_END_OF_CYCLE_FLAG    = 7;
    localparam int CMTX_MSC_DIV_LSB = 5;
    localparam int CMTX_MSC_EXTENDED_SPACE_ENABLE   = 4;
    localparam int CMTX_MSC_BASE    = 3;
    localparam int CMTX_MSC_FSK     = 2;
    localparam int CMTX_MSC_END_OF_CYCLE_IRQ_ENABLE   = 1;
    localparam int CMTX_MSC_MODULATOR_GLOBAL_ENABLE   = 0;

    // Timing constants: time and baseband modes count the carrier clock divided by eight.
    localparam logic [2:0] CMTX_MOD_DIV_LAST = 3'h7;
    localparam logic [7:0] CMTX_CG_RESTART   = 8'h01;

    typedef struct packed {
        logic [7:0]  pri_high;
        logic [7:0]  pri_low;
        logic [7:0]  sec_high;
        logic [7:0]  sec_low;
        logic        latch;
        logic        pol;
        logic        pen;
        logic        end_of_cycle_flag;
        logic [1:0]  div;
        logic        extended_space_enable;
        logic        base;
        logic        fsk;
        logic        end_of_cycle_irq_enable;
        logic        modulator_global_enable;
        logic [15:0] mark;
        logic [15:0] space;
        logic        armed;
        logic        active;
        logic        ext;
        logic        sec;
        logic [16:0] cnt;
        logic [15:0] spc;
        logic [2:0]  pre;
        logic [2:0]  tick8;
        logic [7:0]  cg_cnt;
        logic        carrier;
        logic        pready;
        logic        pslverr;
        logic [7:0]  rdata;
        logic        ir_out;
        logic        ir_oe;
        logic        irq;
    } cmtx_state_t;

    localparam cmtx_state_t CMTX_RESET = '0;

endpackage

// >>> verilog/cmtx_modulator.sv
// Infrared carrier modulator: APB registers, carrier generator, modulator and output pin.
//
// Functional notes
// - Extended space bit set: next period is all space, mark plus space long.
// - Once extended space starts, every following period has no mark while the bit stays set, in all modes.
// - Clearing extended space resumes mark then space at next period start.
// - Frequency-shift mode keeps counting and alternating register sets during extended space.
// - Frequency-shift extended space ends when the clearing period's space completes.
// - Software cannot read whether primary or secondary set is in use.
// - Enabled or finishing the last cycle: pin shows modulator output; idle: pin shows the output latch.
// - Pin polarity is software selectable, high-true or low-true.
// - Setting global enable while idle sets the end-of-cycle flag.
// - While enabled, the flag sets at every cycle end, at counter reload.
// - Re-enable before cycle end: no flag at re-enable, flag at cycle end.
// - After enable is cleared, the final cycle end sets no flag.
// - Flag clears after a status read followed by low mark or space access.
// - Interrupt requested while flag and its enable are both set.
// - Cycle end loads counter and space register from buffers; new values next cycle.
// - Reload happens at every cycle end while enabled, regardless of flag or interrupt handling.
// - In processor wait mode the enabled modulator keeps running unchanged.
// - Stop halts clocks; deepest stops lose registers; lightest keeps and resumes.
// - Background debug freezes all counters until user mode returns.
// - Time mode uses primary counts only; frequency-shift alternates primary and secondary.
// - Latch reads back its state; a write shows only when disabled and pin enabled.
// - Mark counted by 17-bit down counter with zero sign bit; underflow closes gate.
// - Clearing enable lets the cycle finish, then stops clocks and forces output low.
// - Pin enable clear tri-states the pin; pin is disabled during reset.
// - Polarity bit one means active high pin, zero means active low.
module cmtx_modulator
    import cmtx_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // Clock and reset.
    input  wire logic              pclk,
    input  wire logic              presetn,
    // APB slave.
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic [31:0]            prdata,
    output logic                   pslverr,
    // Processor mode inputs, same clock domain.
    input  wire logic              debug_freeze,
    input  wire logic              stop_retain,
    input  wire logic              stop_lose,
    // Infrared pin and interrupt.
    output logic                   infrared_output_pin,
    output logic                   infrared_output_pin_oe,
    output logic                   end_of_cycle_irq
);

    ////////////////////////////////////////////////////////////////////////////////
    // State and helpers.

    cmtx_state_t q;
    cmtx_state_t d;

    logic       freeze;
    logic       setup;
    logic       access;
    logic       wr;
    logic       rd;
    logic [3:0] reg_idx;
    logic       reg_ok;
    logic       cmt_en;
    logic       rise;
    logic       mtick;
    logic       match;
    logic       eoc_set;
    logic       eoc_clr;
    logic [7:0] cg_target;
    logic       mod_out;
    logic       pin_val;

    // Terminal count of the prescaler for divide by 1, 2, 4 or 8.
    function automatic logic [2:0] cmtx_div_last(input logic [1:0] code);
        cmtx_div_last = 3'((4'h1 << code) - 4'h1);
    endfunction

    // Register index for an address; index 4'hF marks an unmapped address.
    function automatic logic [3:0] cmtx_decode(input logic [ADDR_W-1:0] a);
        logic [7:0] b;
        b = 8'(a);
        if (b == CMTX_OFS_PRI_HIGH) cmtx_decode = 4'h0;
        else if (b == CMTX_OFS_PRI_LOW) cmtx_decode = 4'h1;
        else if (b == CMTX_OFS_SEC_HIGH) cmtx_decode = 4'h2;
        else if (b == CMTX_OFS_SEC_LOW) cmtx_decode = 4'h3;
        else if (b == CMTX_OFS_OUT_CTRL) cmtx_decode = 4'h4;
        else if (b == CMTX_OFS_MOD_STAT) cmtx_decode = 4'h5;
        else if (b == CMTX_OFS_MARK_HIGH) cmtx_decode = 4'h6;
        else if (b == CMTX_OFS_MARK_LOW) cmtx_decode = 4'h7;
        else if (b == CMTX_OFS_SPACE_HIGH) cmtx_decode = 4'h8;
        else if (b == CMTX_OFS_SPACE_LOW) cmtx_decode = 4'h9;
        else cmtx_decode = 4'hF;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Next state.

    always_comb begin
        d = q;

        // No wait-mode input exists: the engine never stops for it.
        freeze  = debug_freeze | stop_retain;
        setup   = psel & ~penable;
        access  = psel & penable & q.pready;
        wr      = access & pwrite;
        rd      = access & ~pwrite;
        reg_idx = cmtx_decode(paddr);
        reg_ok  = (reg_idx != 4'hF);

        // Bus answer is prepared in the setup cycle so that every bus output is a flop.
        d.pready  = setup;
        d.pslverr = setup & ~reg_ok;
        d.rdata   = 8'h00;
        if (setup) begin
            case (reg_idx)
                4'h0: d.rdata = q.pri_high;
                4'h1: d.rdata = q.pri_low;
                4'h2: d.rdata = q.sec_high;
                4'h3: d.rdata = q.sec_low;
                4'h4: d.rdata = {q.latch, q.pol, q.pen, 5'h00};
                // The primary/secondary selector is deliberately not visible here.
                4'h5: d.rdata = {q.end_of_cycle_flag, q.div, q.extended_space_enable, q.base, q.fsk, q.end_of_cycle_irq_enable, q.modulator_global_enable};
                4'h6: d.rdata = q.mark[15:8];
                4'h7: d.rdata = q.mark[7:0];
                4'h8: d.rdata = q.space[15:8];
                4'h9: d.rdata = q.space[7:0];
                default: d.rdata = 8'h00;
            endcase
        end

        // Carrier generator and prescaler, both stopped while frozen or idle.
        cmt_en    = q.active & ~freeze & (q.pre == cmtx_div_last(q.div));
        rise      = 1'b0;
        cg_target = q.carrier ? q.pri_high : q.pri_low;
        if (q.fsk && q.sec) begin
            cg_target = q.carrier ? q.sec_high : q.sec_low;
        end
        if (q.active && !freeze) begin
            d.pre = cmt_en ? 3'h0 : q.pre + 3'h1;
        end
        if (cmt_en) begin
            d.tick8 = q.tick8 + 3'h1;
            if (q.base) begin
                d.carrier = 1'b1;
            end else if (q.cg_cnt == cg_target) begin
                d.cg_cnt  = CMTX_CG_RESTART;
                d.carrier = ~q.carrier;
                rise      = ~q.carrier;
            end else begin
                d.cg_cnt = q.cg_cnt + 8'h01;
            end
        end

        // Frequency-shift mode counts carrier periods, others count the divided clock.
        mtick = q.fsk ? rise : (cmt_en & (q.tick8 == CMTX_MOD_DIV_LAST));

        // After underflow the complement of the counter climbs from zero to the space count.
        match   = q.active & ~freeze & q.cnt[16] & (~q.cnt[15:0] == q.spc);
        eoc_set = 1'b0;
        if (match) begin
            if (q.modulator_global_enable) begin
                d.cnt   = {1'b0, q.mark};
                d.spc   = q.space;
                // Extended space is sampled only here and at start from idle, so it starts and stops on period bounds.
                d.ext   = q.extended_space_enable;
                d.sec   = q.fsk & ~q.sec;
                eoc_set = 1'b1;
            end else begin
                // Last cycle finished after enable was dropped: no flag, clocks stop.
                d.active  = 1'b0;
                d.carrier = 1'b0;
                d.ext     = 1'b0;
            end
        end else if (mtick) begin
            d.cnt = q.cnt - 17'h00001;
        end

        // Start of the first transmission from idle.
        if (q.modulator_global_enable && !q.active) begin
            d.active  = 1'b1;
            d.cnt     = {1'b0, q.mark};
            d.spc     = q.space;
            d.ext     = q.extended_space_enable;
            d.sec     = 1'b0;
            d.pre     = 3'h0;
            d.tick8   = 3'h0;
            d.cg_cnt  = CMTX_CG_RESTART;
            d.carrier = 1'b1;
            eoc_set   = 1'b1;
        end

        // Flag clear takes a status read followed by a low mark or low space access.
        eoc_clr = 1'b0;
        if (access && reg_idx == 4'h5 && !pwrite) begin
            d.armed = 1'b1;
        end else if (access && (reg_idx == 4'h7 || reg_idx == 4'h9)) begin
            eoc_clr = q.armed;
            d.armed = 1'b0;
        end
        // A hardware set in the same cycle as the clear wins.
        d.end_of_cycle_flag = eoc_set | (q.end_of_cycle_flag & ~eoc_clr);

        // Software writes.
        if (wr) begin
            case (reg_idx)
                4'h0: d.pri_high = pwdata[7:0];
                4'h1: d.pri_low  = pwdata[7:0];
                4'h2: d.sec_high = pwdata[7:0];
                4'h3: d.sec_low  = pwdata[7:0];
                4'h4: begin
                    d.latch = pwdata[CMTX_OC_LATCH];
                    d.pol   = pwdata[CMTX_OC_POL];
                    d.pen   = pwdata[CMTX_OC_PEN];
                end
                4'h5: begin
                    d.div   = pwdata[CMTX_MSC_DIV_LSB +: 2];
                    d.extended_space_enable = pwdata[CMTX_MSC_EXTENDED_SPACE_ENABLE];
                    d.base  = pwdata[CMTX_MSC_BASE];
                    d.fsk   = pwdata[CMTX_MSC_FSK];
                    d.end_of_cycle_irq_enable = pwdata[CMTX_MSC_END_OF_CYCLE_IRQ_ENABLE];
                    d.modulator_global_enable = pwdata[CMTX_MSC_MODULATOR_GLOBAL_ENABLE];
                end
                4'h6: d.mark[15:8]  = pwdata[7:0];
                4'h7: d.mark[7:0]   = pwdata[7:0];
                4'h8: d.space[15:8] = pwdata[7:0];
                4'h9: d.space[7:0]  = pwdata[7:0];
                default: d.armed = d.armed;
            endcase
        end

        // The deepest stop modes lose every register.
        if (stop_lose) begin
            d = CMTX_RESET;
        end

        // Pin logic works on the next state so the pins stay plain flops.
        mod_out = d.active & ~d.ext & ~d.cnt[16] & (d.base | d.carrier);
        pin_val = (d.modulator_global_enable | d.active) ? mod_out : d.latch;
        d.ir_out = d.pol ? pin_val : ~pin_val;
        d.ir_oe  = d.pen;
        d.irq    = d.end_of_cycle_flag & d.end_of_cycle_irq_enable;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= CMTX_RESET;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs.

    assign pready                 = q.pready;
    assign prdata                 = {24'h000000, q.rdata};
    assign pslverr                = q.pslverr;
    assign infrared_output_pin    = q.ir_out;
    assign infrared_output_pin_oe = q.ir_oe;
    assign end_of_cycle_irq       = q.irq;

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions.

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // A clear or an enable write in the same cycle may legally drop the request.
    a_irq_from_flag: assert property (
        q.end_of_cycle_flag && q.end_of_cycle_irq_enable && !stop_lose && !eoc_clr && !(wr && reg_idx == 4'h5) |=> end_of_cycle_irq)
        else $error("interrupt not raised for a set flag with enable");

    a_start_sets_flag: assert property (q.modulator_global_enable && !q.active && !stop_lose |=> q.end_of_cycle_flag && q.active)
        else $error("start of transmission did not set the flag");

    a_cycle_reload: assert property (match && q.modulator_global_enable && !stop_lose |=>
        q.cnt == {1'b0, $past(q.mark)} && q.spc == $past(q.space) && q.end_of_cycle_flag)
        else $error("cycle end did not reload buffers and set flag");

    a_last_no_flag: assert property (
        match && !q.modulator_global_enable && !q.end_of_cycle_flag && !stop_lose && !(q.modulator_global_enable && !q.active) |=> !q.active && !q.end_of_cycle_flag)
        else $error("modulator stayed active after last cycle");

    a_ext_gate: assert property (q.active && q.ext && q.pol |-> !infrared_output_pin)
        else $error("mark reached the pin during extended space");

    // The pin flop leaves reset at zero and takes its idle level at the first edge after release.
    a_latch_pin: assert property (!q.modulator_global_enable && !q.active && $past(presetn) |->
        infrared_output_pin == (q.pol ? q.latch : !q.latch))
        else $error("disabled pin does not follow the latch");

    a_pin_enable: assert property (infrared_output_pin_oe == q.pen)
        else $error("pin enable does not follow its control bit");

    a_freeze_hold: assert property (freeze && q.active && !stop_lose && !(q.modulator_global_enable && !q.active)
        |=> q.cnt == $past(q.cnt) && q.cg_cnt == $past(q.cg_cnt))
        else $error("counters moved while frozen");

    a_flag_clear: assert property ($fell(q.end_of_cycle_flag) |-> $past(q.armed) || $past(stop_lose))
        else $error("flag cleared without a prior status read");

    a_time_primary: assert property (match && q.modulator_global_enable && !q.fsk && !stop_lose |=> !q.sec)
        else $error("secondary set selected outside frequency-shift mode");

    a_bus_answer: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("bus answer not one cycle after setup");

    c_start: cover property (q.modulator_global_enable && !q.active ##1 q.active);
    c_ext_space: cover property (match && q.modulator_global_enable && q.extended_space_enable ##1 q.ext);
    c_fsk_toggle: cover property (match && q.modulator_global_enable && q.fsk ##1 q.sec);
    c_flag_clear: cover property (eoc_clr && q.end_of_cycle_flag);

endmodule

// >>> test/cmtx_led_model.sv
// Infrared LED driver model that hangs on the modulator output pin.
module cmtx_led_model (
    // Clock.
    input  wire logic pclk,
    // Pin from the modulator.
    input  wire logic pin,
    input  wire logic oe,
    // Light state seen by the driver.
    output logic      lit,
    output int        pulses
);
    timeunit 1ns;
    timeprecision 1ps;

    // The driver input has a pull-down, so a released pin leaves the LED dark.
    assign lit = oe ? pin : 1'b0;

    initial pulses = 0;

    always @(posedge lit) begin
        pulses++;
    end
endmodule

// >>> test/tb_cmtx_modulator.sv
// Self-checking testbench of the infrared carrier modulator.
module tb_cmtx_modulator
    import cmtx_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;

    logic        pclk, presetn, psel, penable, pwrite;
    logic        debug_freeze, stop_retain, stop_lose;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, pin, pin_oe, irq, lit, err;
    int          bad_count = 0;
    int          num_checks = 0;
    int          n;

    cmtx_modulator #(.ADDR_W(8)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .debug_freeze(debug_freeze), .stop_retain(stop_retain),
        .stop_lose(stop_lose), .infrared_output_pin(pin), .infrared_output_pin_oe(pin_oe),
        .end_of_cycle_irq(irq));
    cmtx_led_model led (.pclk(pclk), .pin(pin), .oe(pin_oe), .lit(lit), .pulses());

    always #5 pclk = ~pclk;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic hang();
        bad_count++;
        $display("timeout at %0t", $time);
        print_verdict();
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge pclk);
    endtask

    // Period lengths carry the prescaler tick phase, so a small slack is allowed.
    task automatic near(input int v, input int e);
        check(32'(v >= e - 3 && v <= e + 3), 32'h1);
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        if (pready !== 1'b1) hang();
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wait_pin(input logic lv);
        for (int i = 0; i < 3000 && pin !== lv; i++) @(posedge pclk);
        if (pin !== lv) hang();
    endtask

    task automatic run_len(input logic lv, input int lim);
        for (n = 0; n < lim && pin === lv; n++) @(posedge pclk);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        for (int i = 0; i < 10; i++) begin
            apb(1'b0, 8'(4 * i), 8'h00);
            check(rd, 32'h0);
        end
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, 8'(4 * i), 8'(8'h11 * (i + 1)));
            apb(1'b0, 8'(4 * i), 8'h00);
            check(rd, 32'(8'h11 * (i + 1)));
        end
        apb(1'b0, 8'h28, 8'h00);
        check(err, 1'b1);
        check(rd, 32'h0);
        apb(1'b1, CMTX_OFS_MOD_STAT, 8'h80);
        apb(1'b0, CMTX_OFS_MOD_STAT, 8'h00);
        check(rd, 32'h0);
        $display("test regs done");
    endtask

    task automatic t_latch();
        logic [7:0] v;
        for (int i = 0; i < 4; i++) begin
            v = {i[1], i[0], 6'h20};
            apb(1'b1, CMTX_OFS_OUT_CTRL, v);
            cyc(2);
            check(pin, i[0] ? i[1] : !i[1]);
            check(pin_oe, 1'b1);
            apb(1'b0, CMTX_OFS_OUT_CTRL, 8'h00);
            check(rd, 32'(v));
        end
        apb(1'b1, CMTX_OFS_OUT_CTRL, 8'h40);
        cyc(2);
        check({pin_oe, lit}, 2'b00);
        $display("test latch done");
    endtask

    task automatic t_base();
        apb(1'b1, CMTX_OFS_MARK_LOW, 8'h09);
        apb(1'b1, CMTX_OFS_SPACE_LOW, 8'h04);
        apb(1'b1, CMTX_OFS_OUT_CTRL, 8'h60);
        apb(1'b1, CMTX_OFS_MOD_STAT, 8'h0B);
        cyc(3);
        check(irq, 1'b1);
        apb(1'b0, CMTX_OFS_MOD_STAT, 8'h00);
        check(rd, 32'h8B);
        apb(1'b0, CMTX_OFS_MARK_LOW, 8'h00);
        apb(1'b0, CMTX_OFS_MOD_STAT, 8'h00);
        check(rd, 32'h0B);
        apb(1'b0, CMTX_OFS_MARK_LOW, 8'h00);
        cyc(2);
        check(irq, 1'b0);
        wait_pin(1'b0);
        wait_pin(1'b1);
        run_len(1'b1, 400);
        near(n, 80);
        run_len(1'b0, 400);
        near(n, 32);
        // Space low access without a status read first must leave the flag alone.
        apb(1'b1, CMTX_OFS_SPACE_LOW, 8'h04);
        apb(1'b0, CMTX_OFS_MOD_STAT, 8'h00);
        check(rd, 32'h8B);
        apb(1'b1, CMTX_OFS_SPACE_LOW, 8'h04);
        apb(1'b0, CMTX_OFS_MOD_STAT, 8'h00);
        check(rd, 32'h0B);
        apb(1'b0, CMTX_OFS_MARK_LOW, 8'h00);
        $display("test base done");
    endtask

    task automatic t_extended_space_enable();
        wait_pin(1'b1);
        apb(1'b1, CMTX_OFS_MOD_STAT, 8'h1B);
        wait_pin(1'b0);
        apb(1'b1, CMTX_OFS_OUT_CTRL, 8'hE0);
        apb(1'b0, CMTX_OFS_MOD_STAT, 8'h00);
        apb(1'b0, CMTX_OFS_MARK_LOW, 8'h00);
        run_len(1'b0, 400);
        check(n, 400);
        apb(1'b0, CMTX_OFS_MOD_STAT, 8'h00);
        check(rd, 32'h9B);
        apb(1'b0, CMTX_OFS_MARK_LOW, 8'h00);
        apb(1'b1, CMTX_OFS_OUT_CTRL, 8'h60);
        apb(1'b1, CMTX_OFS_MOD_STAT, 8'h0B);
        wait_pin(1'b1);
        run_len(1'b1, 400);
        near(n, 80);
        $display("test extended_space_enable done");
    endtask

    task automatic t_hold(input logic [1:0] k);
        wait_pin(1'b0);
        wait_pin(1'b1);
        cyc(20);
        {stop_retain, debug_freeze} <= k;
        cyc(100);
        check(pin, 1'b1);
        {stop_retain, debug_freeze} <= 2'b00;
        run_len(1'b1, 400);
        near(n, 60);
        $display("test hold done");
    endtask

    task automatic t_disable();
        wait_pin(1'b1);
        apb(1'b0, CMTX_OFS_MOD_STAT, 8'h00);
        apb(1'b0, CMTX_OFS_MARK_LOW, 8'h00);
        apb(1'b1, CMTX_OFS_MOD_STAT, 8'h0A);
        apb(1'b1, CMTX_OFS_MOD_STAT, 8'h0B);
        apb(1'b0, CMTX_OFS_MOD_STAT, 8'h00);
        check(rd, 32'h0B);
        apb(1'b0, CMTX_OFS_MARK_LOW, 8'h00);
        wait_pin(1'b0);
        wait_pin(1'b1);
        apb(1'b0, CMTX_OFS_MOD_STAT, 8'h00);
        check(rd, 32'h8B);
        apb(1'b0, CMTX_OFS_MARK_LOW, 8'h00);
        apb(1'b1, CMTX_OFS_MOD_STAT, 8'h0A);
        wait_pin(1'b0);
        run_len(1'b0, 300);
        check(n, 300);
        apb(1'b0, CMTX_OFS_MOD_STAT, 8'h00);
        check(rd, 32'h0A);
        check(irq, 1'b0);
        $display("test disable done");
    endtask

    task automatic t_stop();
        stop_lose <= 1'b1;
        cyc(2);
        stop_lose <= 1'b0;
        apb(1'b0, CMTX_OFS_PRI_HIGH, 8'h00);
        check(rd, 32'h0);
        apb(1'b0, CMTX_OFS_OUT_CTRL, 8'h00);
        check(rd, 32'h0);
        check(pin_oe, 1'b0);
        $display("test stop done");
    endtask

    task automatic t_fsk();
        apb(1'b1, CMTX_OFS_PRI_HIGH, 8'h02);
        apb(1'b1, CMTX_OFS_PRI_LOW, 8'h02);
        apb(1'b1, CMTX_OFS_SEC_HIGH, 8'h14);
        apb(1'b1, CMTX_OFS_SEC_LOW, 8'h14);
        apb(1'b1, CMTX_OFS_MARK_LOW, 8'h01);
        apb(1'b1, CMTX_OFS_SPACE_LOW, 8'h01);
        apb(1'b1, CMTX_OFS_OUT_CTRL, 8'h60);
        // Divide by two: primary pulses last about 4 clocks, secondary pulses about 40.
        apb(1'b1, CMTX_OFS_MOD_STAT, 8'h25);
        wait_pin(1'b1);
        run_len(1'b1, 200);
        near(n, 4);
        for (int j = 0; j < 8 && n < 10; j++) begin
            wait_pin(1'b0);
            wait_pin(1'b1);
            run_len(1'b1, 200);
        end
        near(n, 40);
        apb(1'b0, CMTX_OFS_MOD_STAT, 8'h00);
        check(rd, 32'hA5);
        for (int j = 0; j < 8 && n > 10; j++) begin
            wait_pin(1'b0);
            wait_pin(1'b1);
            run_len(1'b1, 200);
        end
        near(n, 4);
        apb(1'b1, CMTX_OFS_MOD_STAT, 8'h35);
        for (int j = 0; j < 8 && n < 400; j++) begin
            wait_pin(1'b0);
            run_len(1'b0, 400);
        end
        check(n, 400);
        apb(1'b1, CMTX_OFS_MOD_STAT, 8'h25);
        wait_pin(1'b1);
        run_len(1'b1, 200);
        check(32'((n >= 2 && n <= 5) || (n >= 36 && n <= 42)), 32'h1);
        $display("test fsk done");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        {psel, penable, pwrite, debug_freeze, stop_retain, stop_lose} = 6'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        cyc(20);
        check({pin_oe, irq}, 2'b00);
        presetn <= 1'b1;
        cyc(3);
        check({pin, pin_oe}, 2'b10);
        t_regs();
        t_latch();
        t_base();
        t_extended_space_enable();
        t_hold(2'b01);
        t_hold(2'b10);
        t_disable();
        t_stop();
        t_fsk();
        print_verdict();
    end
endmodule
